// ===== rtl/cmd_consts.svh
/*
  Constants of the basic command handler: packet codes, classes,
  key bytes, sizes, reset values and timing figures.
  Assumes a 250 MHz system clock.
*/
`ifndef CMD_CONSTS_SVH
`define CMD_CONSTS_SVH

// ==========================================================
// Packet type byte
`define CLS_CMD         2'h0
`define CLS_RSP         2'h1
`define CLS_ERR         2'h3
`define CODE_ECHO       6'h00
`define CODE_VERSION    6'h01
`define CODE_USER_WR    6'h02
`define CODE_USER_RD    6'h03
`define CODE_STORE_BOOT 6'h04
`define CODE_RESTART    6'h05
`define CODE_CLEAR      6'h06
`define CODE_OLD_TEXT   6'h07

// ==========================================================
// Sizes
`define PAYLOAD_MAX     8'h10
`define USER_BYTES      8'h10
`define KEY_LEN         8'h03
`define CFG_W           64
`define BLANK_CHAR      8'h20

// ==========================================================
// Key byte triplets of the restart command
`define KEY_SELF        24'h631208
`define KEY_HOST_RST    24'h611c0c
`define KEY_HOST_OFF    24'h5f0b03

// ==========================================================
// Reset values
`define BOOT_CFG_WELCOME 64'h0000_0000_0000_0001

// ==========================================================
// Timing
`define CLK_HZ          250000000
`define HOST_RST_MS     1500
`define REBOOT_WAIT_MS  3000
`define CYC_PER_MS      (`CLK_HZ / 1000)

`endif

// ===== rtl/cmd_pkg.sv
/*
  Types of the basic command handler: packet carriers, states
  and the handler's whole state record.
  Assumes cmd_consts.svh is on the include path.
*/
`default_nettype none
`include "cmd_consts.svh"

package cmd_pkg;

  // ========================================================
  // Decoded packet carrier, payload byte i at bits 8i+7:8i
  typedef struct packed {
    logic         valid;
    logic [7:0]   ptype;
    logic [7:0]   len;
    logic [127:0] data;
  } pkt_t;

  // ========================================================
  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_HRST = 4'b0010,
    ST_PCYC = 4'b0100,
    ST_WAIT = 4'b1000
  } seq_state_t;

  // ========================================================
  // Whole state of the handler
  typedef struct packed {
    seq_state_t          st;
    logic [31:0]         cnt;
    logic [127:0]        user;
    logic [`CFG_W-1:0]   boot_cfg;
    pkt_t                rsp;
    logic                busy;
    logic                boot_load;
    logic                disp_clear;
    logic                host_rst;
    logic                host_pwr;
  } hdl_state_t;

endpackage

`default_nettype wire

// ===== rtl/module_basic_command_handler.sv
/*
  Basic command handler: decodes checked host packets of codes
  0 to 7 and answers each with one response or error packet.
  Keeps the user area and the boot state, sequences host reset,
  host power cycling and its own restart.
  Assumes framing and CRC are handled outside, one packet is
  offered at a time, and the display logic reacts to disp_clear
  and boot_load.
*/
`default_nettype none
`include "cmd_consts.svh"

// Contract
// R1: Echo code 0x00, payload up to 16
// R2: Echo answer copies packet, type 0x40
// R3: Version query answers 0x41, 16 chars
// R4: User write takes 16 bytes, acks 0x42
// R5: User read returns 16 bytes, type 0x43
// R6: Store boot state saves settings, acks 0x44
// R7: Power-up restores boot state configuration
// R8: Reporting and watchdog never saved at boot; code stores the whole cur_cfg word
// R9: Keys 8,18,99 restart the module
// R10: Ack first, then restart, ignore commands
// R11: Keys 12,28,97 drive host reset line
// R12: Host reset about 1.5 s, then restart
// R13: Keys 3,11,95 drive host power line
// R14: Power cycle for pulse length, then restart
// R15: Restart requests all acknowledged with 0x45
// R16: Clear fills blanks, homes cursor, 0x46
// R17: Host avoids deprecated code 0x07
// R18: Host keeps control pins default mode
// R19: Host may zero fans to boot faster
// R20: Type byte holds class and code
// R21: Packet type, length, payload, CRC
// R22: Every packet answered within 250 ms
// R23: Answer carries the command's code
// R24: Bad length or keys get error
module module_basic_command_handler #(
  parameter int unsigned  HOST_RST_CYC =
    `HOST_RST_MS * `CYC_PER_MS,
  parameter int unsigned  REBOOT_WAIT_CYC =
    `REBOOT_WAIT_MS * `CYC_PER_MS,
  parameter logic [127:0] VERSION_TEXT = "MODULE:h1.0,v1.0"
) (
  input  wire logic              clk_sys,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire cmd_pkg::pkt_t     cmd,
  input  wire logic [`CFG_W-1:0] cur_cfg,
  input  wire logic [31:0]       pwr_pulse_cycles,
  output var  cmd_pkg::pkt_t     rsp,
  output var  logic              busy,
  output var  logic              boot_load,
  output var  logic [`CFG_W-1:0] boot_cfg,
  output var  logic              disp_clear,
  output var  logic              host_rst_drive,
  output var  logic              host_pwr_drive
);
  import cmd_pkg::*;

  // VERSION_TEXT is an arbitrary neutral identity string

  // ========================================================
  // Helpers

  // Reverse a 16-character string so the first char is byte 0
  function automatic logic [127:0] text_to_bytes(
    input logic [127:0] t
  );
    logic [127:0] r;
    r = '0;
    for (int i = 0; i < 16; i++)
    begin
      r[8*i +: 8] = t[8*(15-i) +: 8];
    end
    return r;
  endfunction

  // Compare payload bytes 0..2 with a key triplet
  function automatic logic key_is(
    input logic [127:0] d,
    input logic [23:0]  key
  );
    return d[23:0] == key;
  endfunction

  // Count reached a length, zero lengths treated as one cycle
  function automatic logic count_done(
    input logic [31:0] c,
    input logic [31:0] limit
  );
    return (c + 32'h0000_0001) >= limit;
  endfunction

  localparam logic [31:0] HRST_LIM = 32'(HOST_RST_CYC);
  localparam logic [31:0] WAIT_LIM = 32'(REBOOT_WAIT_CYC);

  // ========================================================
  // State

  hdl_state_t state_q;
  hdl_state_t state_d;
  logic [5:0] code;
  logic       ok;

  assign code = cmd.ptype[5:0];

  // ========================================================
  // Next-state logic
  always_comb
  begin
    state_d            = state_q;
    ok                 = 1'b1;
    state_d.rsp        = '0;
    state_d.boot_load  = 1'b0;
    state_d.disp_clear = 1'b0;
    case (state_q.st)
      ST_IDLE:
      begin
        state_d.host_rst = 1'b0;
        state_d.host_pwr = 1'b0;
        if (cmd.valid)
        begin
          // Answer keeps the command code
          state_d.rsp.ptype = {`CLS_RSP, code}; // R20 R23
          if (cmd.ptype[7:6] != `CLS_CMD) // R20
          begin
            ok = 1'b0;
          end
          else
          begin
            case (code)
              `CODE_ECHO:
              begin
                if (cmd.len <= `PAYLOAD_MAX) // R1
                begin
                  state_d.rsp.len  = cmd.len; // R2 R21
                  state_d.rsp.data = cmd.data; // R2
                end
                else
                begin
                  ok = 1'b0; // R24
                end
              end
              `CODE_VERSION:
              begin
                if (cmd.len == 8'h00)
                begin
                  state_d.rsp.len  = `USER_BYTES; // R3
                  state_d.rsp.data = text_to_bytes(VERSION_TEXT); // R3
                end
                else
                begin
                  ok = 1'b0; // R24
                end
              end
              `CODE_USER_WR:
              begin
                if (cmd.len == `USER_BYTES) // R4
                begin
                  state_d.user = cmd.data; // R4
                end
                else
                begin
                  ok = 1'b0; // R24
                end
              end
              `CODE_USER_RD:
              begin
                if (cmd.len == 8'h00)
                begin
                  state_d.rsp.len  = `USER_BYTES; // R5
                  state_d.rsp.data = state_q.user; // R5
                end
                else
                begin
                  ok = 1'b0; // R24
                end
              end
              `CODE_STORE_BOOT:
              begin
                if (cmd.len == 8'h00)
                begin
                  // Snapshot takes the whole cur_cfg word, no bits masked out
                  state_d.boot_cfg = cur_cfg; // R6 R8
                end
                else
                begin
                  ok = 1'b0; // R24
                end
              end
              `CODE_RESTART:
              begin
                // Ack now, sequence starts next cycle
                if (cmd.len != `KEY_LEN)
                begin
                  ok = 1'b0; // R24
                end
                else if (key_is(cmd.data, `KEY_SELF)) // R9
                begin
                  state_d.st  = ST_WAIT; // R10 R15
                  state_d.cnt = '0;
                end
                else if (key_is(cmd.data, `KEY_HOST_RST)) // R11
                begin
                  state_d.st  = ST_HRST; // R12 R15
                  state_d.cnt = '0;
                end
                else if (key_is(cmd.data, `KEY_HOST_OFF)) // R13
                begin
                  state_d.st  = ST_PCYC; // R14 R15
                  state_d.cnt = '0;
                end
                else
                begin
                  ok = 1'b0; // R24
                end
              end
              `CODE_CLEAR:
              begin
                if (cmd.len == 8'h00)
                begin
                  state_d.disp_clear = 1'b1; // R16
                end
                else
                begin
                  ok = 1'b0; // R24
                end
              end
              default:
              begin
                // Deprecated and foreign codes are refused
                ok = 1'b0; // R17
              end
            endcase
          end
          if (!ok)
          begin
            state_d.rsp.ptype = {`CLS_ERR, code}; // R24
            state_d.rsp.len   = 8'h00;
            state_d.rsp.data  = '0;
          end
          state_d.rsp.valid = 1'b1; // R22
        end
      end
      ST_HRST:
      begin
        // Hold host reset, then restart self
        state_d.host_rst = 1'b1; // R12
        state_d.cnt      = state_q.cnt + 32'h0000_0001;
        if (count_done(state_q.cnt, HRST_LIM)) // R12
        begin
          // Line stays up this last cycle, wait state drops it
          state_d.st       = ST_WAIT;
          state_d.cnt      = '0;
        end
      end
      ST_PCYC:
      begin
        // Hold host power line for the configured pulse
        state_d.host_pwr = 1'b1; // R14
        state_d.cnt      = state_q.cnt + 32'h0000_0001;
        if (count_done(state_q.cnt, pwr_pulse_cycles)) // R14
        begin
          // Line stays up this last cycle, wait state drops it
          state_d.st       = ST_WAIT;
          state_d.cnt      = '0;
        end
      end
      ST_WAIT:
      begin
        // Restart: reload boot state, ignore commands meanwhile
        state_d.host_rst = 1'b0;
        state_d.host_pwr = 1'b0;
        state_d.boot_load = (state_q.cnt == 32'h0000_0000); // R7
        state_d.cnt       = state_q.cnt + 32'h0000_0001;
        if (count_done(state_q.cnt, WAIT_LIM)) // R10
        begin
          state_d.st  = ST_IDLE;
          state_d.cnt = '0;
        end
      end
      default:
      begin
        state_d.st  = ST_WAIT;
        state_d.cnt = '0;
      end
    endcase
    state_d.busy = (state_d.st != ST_IDLE);
  end

  // ========================================================
  // State register, power-up enters restart
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_q          <= '0;
      state_q.st       <= ST_WAIT; // R7
      state_q.busy     <= 1'b1;
      state_q.boot_cfg <= `BOOT_CFG_WELCOME; // R7
    end
    else if (ce)
    begin
      state_q <= state_d;
    end
  end

  // ========================================================
  // Outputs straight from the state register
  assign rsp            = state_q.rsp;
  assign busy           = state_q.busy;
  assign boot_load      = state_q.boot_load;
  assign boot_cfg       = state_q.boot_cfg;
  assign disp_clear     = state_q.disp_clear;
  assign host_rst_drive = state_q.host_rst; // R11
  assign host_pwr_drive = state_q.host_pwr; // R13

endmodule // module_basic_command_handler

`default_nettype wire

// ===== testbench/host_model.sv
/*
  Host model: offers one command packet at a time and keeps
  the answer. Assumes answers come one cycle after taking.
*/
`default_nettype none
module host_model (
  input  wire logic          clk_sys,
  input  wire logic          busy,
  input  wire cmd_pkg::pkt_t rsp,
  output var  cmd_pkg::pkt_t cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  import cmd_pkg::*;
  pkt_t got;
  initial cmd = '0;
  // ========================================================
  // Offer one packet, waiting for idle when w is set
  task automatic send(
    input  logic [7:0]   t,
    input  logic [7:0]   n,
    input  logic [127:0] d,
    input  logic         w,
    output logic         ok
  );
    int i;
    i = 0;
    while (w && busy !== 1'b0 && i < 99)
    begin
      @(posedge clk_sys);
      #1;
      i++;
    end
    ok = (busy === 1'b0) || !w;
    @(posedge clk_sys);
    // Any type byte t goes out unchecked, codes above 7 included
    cmd <= {1'b1, t, n, d};
    @(posedge clk_sys);
    cmd <= {1'b0, ~t, ~n, ~d};
    #1;
    got = rsp;
  endtask
endmodule // host_model
`default_nettype wire

// ===== testbench/cmd_properties.sv
/*
  Port checker of the command handler.
  Assumes one clock and a host that offers checked packets.
*/
`default_nettype none
`include "cmd_consts.svh"
module cmd_properties (
  input wire logic              clk_sys,
  input wire logic              rst,
  input wire logic              ce,
  input wire cmd_pkg::pkt_t     cmd,
  input wire cmd_pkg::pkt_t     rsp,
  input wire logic              busy,
  input wire logic              boot_load,
  input wire logic [`CFG_W-1:0] boot_cfg,
  input wire logic [`CFG_W-1:0] cur_cfg,
  input wire logic              disp_clear,
  input wire logic              host_rst_drive,
  input wire logic              host_pwr_drive
);
  import cmd_pkg::*;
  logic       tk;
  logic [7:0] ty;
  // Packet taken at this edge
  assign tk = ce && cmd.valid && !busy;
  assign ty = cmd.ptype;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // ========================================================
  // Restart request with one key triplet
  sequence s_key(k);
    tk && ty == 8'h05 && cmd.len == 8'h03 && cmd.data[23:0] == k;
  endsequence
  chk_answer_next: assert property (tk |=> rsp.valid)
    else $error("no answer after packet");
  chk_no_spurious: assert property (rsp.valid |-> $past(tk))
    else $error("answer without packet");
  chk_code_kept: assert property (
    tk |=> rsp.ptype[5:0] == $past(ty[5:0]))
    else $error("answer code differs");
  chk_echo_copy: assert property (
    tk && ty == 8'h00 && cmd.len <= 8'h10 |=> rsp.ptype == 8'h40
    && rsp.len == $past(cmd.len) && rsp.data == $past(cmd.data))
    else $error("echo answer differs");
  chk_bad_class: assert property (
    tk && ty[7:6] != 2'h0 |=> rsp.ptype[7:6] == 2'h3 && rsp.len == 8'h00)
    else $error("bad class accepted");
  chk_clear_pulse: assert property (
    tk && ty == 8'h06 && cmd.len == 8'h00
    |=> rsp.ptype == 8'h46 && disp_clear ##1 !disp_clear)
    else $error("clear pulse wrong");
  chk_store_boot: assert property (
    tk && ty == 8'h04 && cmd.len == 8'h00
    |=> rsp.ptype == 8'h44 && boot_cfg == $past(cur_cfg))
    else $error("boot state not stored");
  chk_restart_ack: assert property (
    s_key(`KEY_SELF) or s_key(`KEY_HOST_RST) or s_key(`KEY_HOST_OFF)
    |=> rsp.ptype == 8'h45 && rsp.len == 8'h00 && busy)
    else $error("restart not acknowledged");
  chk_self_boot: assert property (
    s_key(`KEY_SELF) |=> !boot_load ##1 boot_load ##1 !boot_load)
    else $error("self restart pulse wrong");
  chk_host_reset: assert property (
    s_key(`KEY_HOST_RST) |=> !host_rst_drive ##1 host_rst_drive && busy)
    else $error("host reset line wrong");
  chk_host_off: assert property (
    s_key(`KEY_HOST_OFF) |=> !host_pwr_drive ##1 host_pwr_drive && busy)
    else $error("host power line wrong");
  chk_boot_busy: assert property (
    boot_load |-> busy && !host_rst_drive && !host_pwr_drive)
    else $error("restore outside wait");
endmodule // cmd_properties
bind module_basic_command_handler cmd_properties i_chk (
  .clk_sys, .rst, .ce, .cmd, .rsp, .busy, .boot_load, .boot_cfg,
  .cur_cfg, .disp_clear, .host_rst_drive, .host_pwr_drive
);
`default_nettype wire

// ===== testbench/tb.sv
/*
  Bench of the command handler: one task per scenario.
  Assumes host_model and cmd_properties are compiled first.
*/
`default_nettype none
`include "cmd_consts.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cmd_pkg::*;
  localparam logic [127:0] VTXT = "MODULE:h1.0,v1.0";
  localparam int           HRST = 8;
  localparam logic [127:0] U = 128'h0f1e2d3c4b5a69788796a5b4c3d2e1f0;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic [63:0] cur_cfg = 64'h0123_4567_89ab_cdef;
  logic [31:0] pwr_pulse_cycles = 32'h5;
  logic [63:0] boot_cfg;
  logic        busy, boot_load, disp_clear, host_rst_drive, host_pwr_drive;
  pkt_t        cmd, rsp;
  logic        ok;
  int          err_total = 0;
  int          n_tests = 0;
  module_basic_command_handler #(
    .HOST_RST_CYC    (HRST),
    .REBOOT_WAIT_CYC (16),
    .VERSION_TEXT    (VTXT)
  ) i_dut (
    .clk_sys, .rst, .ce, .cmd, .cur_cfg, .pwr_pulse_cycles, .rsp,
    .busy, .boot_load, .boot_cfg, .disp_clear, .host_rst_drive,
    .host_pwr_drive
  );
  host_model i_host (.clk_sys, .busy, .rsp, .cmd);
  initial forever #2 clk_sys = ~clk_sys;
  // ========================================================
  // Reporting and shared steps
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic c, input string m);
    n_tests++;
    if (c !== 1'b1)
    begin
      err_total++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  // Send when idle and compare the whole answer
  task automatic xr(input logic [7:0] t, n, input logic [127:0] d,
    input logic [7:0] et, en, input logic [127:0] ed, input string m);
    i_host.send(t, n, d, 1'b1, ok);
    chk(ok, "idle wait ran out");
    if (!ok)
      final_report();
    chk(i_host.got === {1'b1, et, en, ed}, m);
  endtask
  // Count line and pulse cycles until busy falls
  task automatic settle(output int nr, np, nb);
    nr = 0;
    np = 0;
    nb = 0;
    for (int i = 0; i < 99 && busy !== 1'b0; i++)
    begin
      @(posedge clk_sys);
      #1;
      nr += int'(host_rst_drive);
      np += int'(host_pwr_drive);
      nb += int'(boot_load);
    end
    chk(busy === 1'b0, "busy stuck");
    if (busy !== 1'b0)
      final_report();
  endtask
  // ========================================================
  // Scenarios
  task automatic t_boot();
    int nr, np, nb;
    chk(boot_cfg === `BOOT_CFG_WELCOME, "boot state value");
    settle(nr, np, nb);
    chk(nb === 1, "no restore after reset");
  endtask
  task automatic t_echo();
    logic [7:0] n [3] = '{8'h00, 8'h05, 8'h10};
    for (int i = 0; i < 3; i++)
      xr(8'h00, n[i], U, 8'h40, n[i], U, "echo answer");
    xr(8'h00, 8'h11, U, 8'hc0, 8'h00, '0, "long echo");
  endtask
  task automatic t_version();
    logic [127:0] e;
    for (int i = 0; i < 16; i++)
      e[8*i +: 8] = VTXT[8*(15-i) +: 8];
    xr(8'h01, 8'h00, '0, 8'h41, 8'h10, e, "version text");
  endtask
  task automatic t_user();
    xr(8'h02, 8'h10, U, 8'h42, 8'h00, '0, "user write");
    xr(8'h03, 8'h00, '0, 8'h43, 8'h10, U, "user read");
    xr(8'h02, 8'h0f, ~U, 8'hc2, 8'h00, '0, "short write");
    xr(8'h03, 8'h00, '0, 8'h43, 8'h10, U, "user changed");
  endtask
  task automatic t_store();
    xr(8'h04, 8'h00, '0, 8'h44, 8'h00, '0, "store ack");
    chk(boot_cfg === cur_cfg, "boot state stored");
    xr(8'h04, 8'h01, '0, 8'hc4, 8'h00, '0, "store length");
  endtask
  task automatic t_clear();
    xr(8'h06, 8'h00, '0, 8'h46, 8'h00, '0, "clear ack");
    chk(disp_clear === 1'b1, "clear pulse");
    @(posedge clk_sys);
    #1;
    chk(disp_clear === 1'b0, "clear pulse length");
  endtask
  task automatic t_restart();
    logic [23:0] k [3] = '{{8'h63, 8'h12, 8'h08},
      {8'h61, 8'h1c, 8'h0c}, {8'h5f, 8'h0b, 8'h03}};
    int nr, np, nb;
    for (int i = 0; i < 3; i++)
    begin
      xr(8'h05, 8'h03, {104'h0, k[i]}, 8'h45, 8'h00, '0, "ack");
      chk(busy === 1'b1, "busy after ack");
      settle(nr, np, nb);
      chk(nr === (i == 1 ? HRST : 0), "host reset time");
      chk(np === (i == 2 ? 5 : 0), "power pulse time");
      chk(nb === 1, "no self restart");
    end
    chk(boot_cfg === cur_cfg, "boot state lost");
    xr(8'h03, 8'h00, '0, 8'h43, 8'h10, U, "user lost");
    xr(8'h05, 8'h03, {104'h0, k[0]}, 8'h45, 8'h00, '0, "ack");
    i_host.send(8'h00, 8'h00, '0, 1'b0, ok);
    chk(i_host.got.valid === 1'b0, "taken while busy");
    settle(nr, np, nb);
    xr(8'h05, 8'h03, 128'h096312, 8'hc5, 8'h00, '0, "bad key");
    xr(8'h05, 8'h04, 128'h631208, 8'hc5, 8'h00, '0, "key length");
    chk(busy === 1'b0, "bad key effect");
  endtask
  task automatic t_bad();
    logic [7:0] t [4] = '{8'h07, 8'h08, 8'h3f, 8'h41};
    for (int i = 0; i < 4; i++)
      xr(t[i], 8'h00, '0, {2'h3, t[i][5:0]}, 8'h00, '0, "refused");
  endtask
  // Clock enable low freezes the handler, no packet taken
  task automatic t_enable();
    @(posedge clk_sys);
    ce <= 1'b0;
    i_host.send(8'h06, 8'h00, '0, 1'b1, ok);
    chk(i_host.got.valid === 1'b0, "taken while frozen");
    chk(disp_clear === 1'b0, "clear while frozen");
    @(posedge clk_sys);
    ce <= 1'b1;
    xr(8'h06, 8'h00, '0, 8'h46, 8'h00, '0, "clear after enable");
  endtask
  // ========================================================
  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    t_boot();
    t_echo();
    t_version();
    t_user();
    t_store();
    t_clear();
    t_restart();
    t_bad();
    t_enable();
    final_report();
  end
endmodule // tb
`default_nettype wire
